// >>> design/llc_pkg.sv
// ********************************************************************
// lighting control register bank: shared constants and types
// ********************************************************************
package llc_pkg;

  // ******************************************************************
  // register offsets on the serial control port
  // ******************************************************************
  localparam logic [7:0] REG_KEY_CTRL = 8'h00; // keypad_control
  localparam logic [7:0] REG_KEY_BAL = 8'h01; // keypad_balance_brightness
  localparam logic [7:0] REG_KEY_CAP = 8'h02; // keypad_max_current
  localparam logic [7:0] REG_BL_CTRL = 8'h03; // backlight_control
  localparam logic [7:0] REG_EXT_PWM = 8'h2B; // external_pwm_routing

  // ******************************************************************
  // writable bit masks; bits outside a mask are read-only zero
  // ******************************************************************
  localparam logic [7:0] MASK_KEY_CTRL = 8'hEE;
  localparam logic [7:0] MASK_KEY_BAL = 8'h7F;
  localparam logic [7:0] MASK_KEY_CAP = 8'h3F;
  localparam logic [7:0] MASK_BL_CTRL = 8'h3F;
  localparam logic [7:0] MASK_EXT_PWM = 8'h1F;

  // ******************************************************************
  // values after reset
  // ******************************************************************
  localparam logic [7:0] RST_KEY_CTRL = 8'h20; // switch mode comes up set
  localparam logic [7:0] RST_KEY_BAL = 8'h00;
  localparam logic [7:0] RST_KEY_CAP = 8'h00;
  localparam logic [7:0] RST_BL_CTRL = 8'h00;
  localparam logic [7:0] RST_EXT_PWM = 8'h00;

  // ******************************************************************
  // field positions
  // ******************************************************************
  localparam int KC_PWM_BIT = 7; // internal_key_pwm_on
  localparam int KC_OUTS_BIT = 6; // key_outputs_on
  localparam int KC_STYLE_BIT = 5; // key_drive_style
  localparam int KC_ONE_BIT = 3; // key_one_on
  localparam int KC_TWO_BIT = 2; // key_two_on
  localparam int KC_THREE_BIT = 1; // key_three_on
  localparam int KB_BAL_LSB = 4; // balance field 6:4
  localparam int KB_LVL_LSB = 1; // key_pwm_level 3:1
  localparam int KB_OVL_BIT = 0; // overlap_on
  localparam int KM_ONE_LSB = 4; // key_one_current_cap 5:4
  localparam int KM_TWO_LSB = 2; // key_two_current_cap 3:2
  localparam int KM_THREE_LSB = 0; // key_three_current_cap 1:0
  localparam int BL_DUR_BIT = 5; // fade_duration_sel
  localparam int BL_SEL_BIT = 4; // fade target string
  localparam int BL_FADE_BIT = 3; // fade enable
  localparam int BL_GANG_BIT = 2; // backlight_gang
  localparam int BL_PRI_BIT = 1; // primary string enable
  localparam int BL_SEC_BIT = 0; // secondary string enable
  localparam int EP_ONE_BIT = 4; // key_one_ext_pwm
  localparam int EP_TWO_BIT = 3; // key_two_ext_pwm
  localparam int EP_THREE_BIT = 2; // key_three_ext_pwm
  localparam int EP_PRI_BIT = 1; // primary string external pwm
  localparam int EP_SEC_BIT = 0; // secondary string external pwm

  // ******************************************************************
  // serial port and timing constants
  // ******************************************************************
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2C; // arbitrary value
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int CLK_KHZ = 100000; // 100 MHz core clock
  localparam int FADE_SHORT_MS = 650; // full-scale fade, short setting
  localparam int FADE_LONG_MS = 1300; // full-scale fade, long setting
  localparam int FADE_STEPS = 255; // steps in a full-scale fade
  localparam int FADE_SHORT_STEP_CYC = (FADE_SHORT_MS * CLK_KHZ) / FADE_STEPS;
  localparam int FADE_LONG_STEP_CYC = (FADE_LONG_MS * CLK_KHZ) / FADE_STEPS;
  localparam int FADE_CNT_W = 20; // holds the longer step count

  // ******************************************************************
  // serial port states
  // ******************************************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ADDR = 4'b0001,
    ST_ADDR_ACK = 4'b0010,
    ST_REG = 4'b0011,
    ST_REG_ACK = 4'b0100,
    ST_WDATA = 4'b0101,
    ST_WDATA_ACK = 4'b0110,
    ST_RDATA = 4'b0111,
    ST_RDATA_ACK = 4'b1000
  } llc_state_t;

  // ******************************************************************
  // carriers toward the keypad and backlight drivers
  // ******************************************************************
  typedef struct packed {
    logic pwmOn; // internal keypad pwm controller runs
    logic switchMode; // 1 switch mode, 0 constant current sink
    logic [2:0] active; // per key: master and own enable both set
    logic [2:0] balance;
    logic [2:0] level;
    logic overlap;
    logic [1:0] oneCap; // 00..11: quarter to full maximum current
    logic [1:0] twoCap;
    logic [1:0] threeCap;
    logic [2:0] extPwm; // external pwm per key, one..three
  } llc_key_t;

  typedef struct packed {
    logic fadeLong; // 1 selects the long fade duration
    logic fadePrimary; // fade runs on the primary string
    logic fadeSecondary; // fade runs on the secondary string
    logic gang; // both strings follow the primary setting
    logic primaryOn;
    logic secondaryOn;
    logic primaryExt;
    logic secondaryExt;
  } llc_bl_t;

endpackage : llc_pkg

// >>> design/llc_regs.sv
`timescale 1ns/10ps
`default_nettype none
module llc_regs
  import llc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = llc_pkg::DEV_ADDR_DEFAULT, // arbitrary value
  parameter int FADE_SHORT_CYC = llc_pkg::FADE_SHORT_STEP_CYC,
  parameter int FADE_LONG_CYC = llc_pkg::FADE_LONG_STEP_CYC
)
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // two-wire serial control pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  // driver settings
  output llc_pkg::llc_key_t keyCfg,
  output llc_pkg::llc_bl_t blCfg,
  output logic fadeStep
);
  import llc_pkg::*;

  // ******************************************************************
  // reset release
  // ******************************************************************
  logic rstMeta_q; // first stage of the reset release
  logic rstN_q; // reset used by the rest of the block

  // async assert, release through two flops
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rstMeta_q <= 1'b0;
      rstN_q <= 1'b0;
    end
    else
    begin
      rstMeta_q <= 1'b1;
      rstN_q <= rstMeta_q;
    end
  end

  // ******************************************************************
  // pin synchronisers and glitch filter
  // ******************************************************************
  logic [2:0] sclSync_q; // bit 0 is the metastable stage
  logic [2:0] sdaSync_q;
  logic sclF_q; // filtered line levels
  logic sdaF_q;
  wire sclNext; // filtered level seen this cycle
  wire sdaNext;
  wire sclRise;
  wire sclFall;
  wire startCond;
  wire stopCond;

  // a level counts only once stages two and three agree
  assign sclNext = (sclSync_q[1] == sclSync_q[2]) ? sclSync_q[2] : sclF_q;
  assign sdaNext = (sdaSync_q[1] == sdaSync_q[2]) ? sdaSync_q[2] : sdaF_q;
  assign sclRise = sclNext & ~sclF_q;
  assign sclFall = ~sclNext & sclF_q;
  // data moving while clock stays high frames a transfer
  assign startCond = sclF_q & sclNext & sdaF_q & ~sdaNext;
  assign stopCond = sclF_q & sclNext & ~sdaF_q & sdaNext;

  // idle bus is high, so the chains reset high
  always_ff @(posedge clk or negedge rstN_q)
  begin
    if (!rstN_q)
    begin
      sclSync_q <= 3'h7;
      sdaSync_q <= 3'h7;
      sclF_q <= 1'b1;
      sdaF_q <= 1'b1;
    end
    else
    begin
      sclSync_q <= {sclSync_q[1:0], sclIn};
      sdaSync_q <= {sdaSync_q[1:0], sdaIn};
      sclF_q <= sclNext;
      sdaF_q <= sdaNext;
    end
  end

  // ******************************************************************
  // register storage and decode
  // ******************************************************************
  logic [7:0] keyCtrl_q;
  logic [7:0] keyBal_q;
  logic [7:0] keyCap_q;
  logic [7:0] blCtrl_q;
  logic [7:0] extPwm_q;
  logic [7:0] ptr_q; // register pointer, advances per byte
  logic [7:0] shift_q; // received byte
  wire wrStrobe; // a full data byte has arrived
  wire [7:0] rdByte; // value for the pointed register

  // read-only bits are forced to zero on every write
  function automatic logic [7:0] maskByte(input logic [7:0] value, input logic [7:0] mask);
    maskByte = value & mask;
  endfunction : maskByte

  // unmapped offsets read zero
  assign rdByte = (ptr_q == REG_KEY_CTRL) ? keyCtrl_q :
                  (ptr_q == REG_KEY_BAL) ? keyBal_q :
                  (ptr_q == REG_KEY_CAP) ? keyCap_q :
                  (ptr_q == REG_BL_CTRL) ? blCtrl_q :
                  (ptr_q == REG_EXT_PWM) ? extPwm_q : 8'h00;

  // writes land on the clock fall that ends the byte's eighth bit
  always_ff @(posedge clk or negedge rstN_q)
  begin
    if (!rstN_q)
    begin
      keyCtrl_q <= RST_KEY_CTRL;
      keyBal_q <= RST_KEY_BAL;
      keyCap_q <= RST_KEY_CAP;
      blCtrl_q <= RST_BL_CTRL;
      extPwm_q <= RST_EXT_PWM;
    end
    else if (wrStrobe)
    begin
      if (ptr_q == REG_KEY_CTRL) keyCtrl_q <= maskByte(shift_q, MASK_KEY_CTRL);
      if (ptr_q == REG_KEY_BAL) keyBal_q <= maskByte(shift_q, MASK_KEY_BAL);
      if (ptr_q == REG_KEY_CAP) keyCap_q <= maskByte(shift_q, MASK_KEY_CAP);
      if (ptr_q == REG_BL_CTRL) blCtrl_q <= maskByte(shift_q, MASK_BL_CTRL);
      if (ptr_q == REG_EXT_PWM) extPwm_q <= maskByte(shift_q, MASK_EXT_PWM);
    end
  end

  // ******************************************************************
  // serial port state machine
  // ******************************************************************
  llc_state_t state_q;
  logic [3:0] bitCnt_q; // clock rises seen in this byte
  logic [7:0] txByte_q; // byte being sent on a read
  logic nack_q; // master declined the last read byte
  wire byteDone;
  wire addrHit;

  assign byteDone = (bitCnt_q == BITS_PER_BYTE);
  assign addrHit = (shift_q[7:1] == DEV_ADDR);
  assign wrStrobe = sclFall & byteDone & (state_q == ST_WDATA);

  // bits are taken on clock rise, driven on clock fall
  always_ff @(posedge clk or negedge rstN_q)
  begin
    if (!rstN_q)
    begin
      state_q <= ST_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      txByte_q <= 8'h00;
      ptr_q <= 8'h00;
      nack_q <= 1'b0;
      sdaOut <= 1'b0;
      sdaOeN <= 1'b1;
    end
    else if (startCond)
    begin
      // a start or repeated start always restarts address phase
      state_q <= ST_ADDR;
      bitCnt_q <= 4'h0;
      sdaOeN <= 1'b1;
    end
    else if (stopCond)
    begin
      state_q <= ST_IDLE;
      sdaOeN <= 1'b1;
    end
    else if (sclRise)
    begin
      // the ninth rise is the acknowledge bit; it must not disturb the byte
      if (!byteDone) shift_q <= {shift_q[6:0], sdaF_q};
      bitCnt_q <= bitCnt_q + 4'h1;
      if (state_q == ST_RDATA_ACK) nack_q <= sdaF_q;
    end
    else if (sclFall)
    begin
      case (state_q)
        ST_ADDR:
        begin
          if (byteDone)
          begin
            // only our own address is answered
            state_q <= addrHit ? ST_ADDR_ACK : ST_IDLE;
            sdaOeN <= ~addrHit;
          end
        end
        ST_ADDR_ACK:
        begin
          bitCnt_q <= 4'h0;
          if (shift_q[0])
          begin
            state_q <= ST_RDATA;
            txByte_q <= rdByte;
            sdaOeN <= rdByte[7];
          end
          else
          begin
            state_q <= ST_REG;
            sdaOeN <= 1'b1;
          end
        end
        ST_REG, ST_WDATA:
        begin
          if (byteDone)
          begin
            state_q <= (state_q == ST_REG) ? ST_REG_ACK : ST_WDATA_ACK;
            sdaOeN <= 1'b0;
          end
        end
        ST_REG_ACK:
        begin
          ptr_q <= shift_q;
          bitCnt_q <= 4'h0;
          state_q <= ST_WDATA;
          sdaOeN <= 1'b1;
        end
        ST_WDATA_ACK:
        begin
          ptr_q <= ptr_q + 8'h01;
          bitCnt_q <= 4'h0;
          state_q <= ST_WDATA;
          sdaOeN <= 1'b1;
        end
        ST_RDATA:
        begin
          if (byteDone)
          begin
            // release so the master can acknowledge
            state_q <= ST_RDATA_ACK;
            sdaOeN <= 1'b1;
            ptr_q <= ptr_q + 8'h01;
          end
          else
          begin
            sdaOeN <= txByte_q[3'h7 - bitCnt_q[2:0]];
          end
        end
        ST_RDATA_ACK:
        begin
          bitCnt_q <= 4'h0;
          if (nack_q)
          begin
            state_q <= ST_IDLE;
            sdaOeN <= 1'b1;
          end
          else
          begin
            state_q <= ST_RDATA;
            txByte_q <= rdByte;
            sdaOeN <= rdByte[7];
          end
        end
        default:
        begin
          sdaOeN <= 1'b1;
        end
      endcase
    end
  end

  // ******************************************************************
  // driver settings decode
  // ******************************************************************
  llc_key_t keyCfg_d;
  llc_bl_t blCfg_d;

  assign keyCfg_d.pwmOn = keyCtrl_q[KC_PWM_BIT];
  assign keyCfg_d.switchMode = keyCtrl_q[KC_STYLE_BIT];
  // master enable gates every per-key enable
  assign keyCfg_d.active = {keyCtrl_q[KC_ONE_BIT], keyCtrl_q[KC_TWO_BIT],
                            keyCtrl_q[KC_THREE_BIT]} & {3{keyCtrl_q[KC_OUTS_BIT]}};
  assign keyCfg_d.balance = keyBal_q[KB_BAL_LSB +: 3];
  assign keyCfg_d.level = keyBal_q[KB_LVL_LSB +: 3];
  assign keyCfg_d.overlap = keyBal_q[KB_OVL_BIT];
  assign keyCfg_d.oneCap = keyCap_q[KM_ONE_LSB +: 2];
  assign keyCfg_d.twoCap = keyCap_q[KM_TWO_LSB +: 2];
  assign keyCfg_d.threeCap = keyCap_q[KM_THREE_LSB +: 2];
  assign keyCfg_d.extPwm = {extPwm_q[EP_ONE_BIT], extPwm_q[EP_TWO_BIT],
                            extPwm_q[EP_THREE_BIT]};
  assign blCfg_d.fadeLong = blCtrl_q[BL_DUR_BIT];
  // fade target is one string at a time, only while fading is on
  assign blCfg_d.fadePrimary = blCtrl_q[BL_FADE_BIT] & ~blCtrl_q[BL_SEL_BIT];
  assign blCfg_d.fadeSecondary = blCtrl_q[BL_FADE_BIT] & blCtrl_q[BL_SEL_BIT];
  assign blCfg_d.gang = blCtrl_q[BL_GANG_BIT];
  assign blCfg_d.primaryOn = blCtrl_q[BL_PRI_BIT];
  assign blCfg_d.secondaryOn = blCtrl_q[BL_SEC_BIT];
  assign blCfg_d.primaryExt = extPwm_q[EP_PRI_BIT];
  assign blCfg_d.secondaryExt = extPwm_q[EP_SEC_BIT];

  // ******************************************************************
  // fade step timer
  // ******************************************************************
  logic [FADE_CNT_W-1:0] fadeCnt_q; // cycles since the last step
  wire [FADE_CNT_W-1:0] fadeLast; // terminal count for chosen duration
  wire fadeRun;

  // one step per 1/255 of the chosen full-scale time
  assign fadeLast = blCtrl_q[BL_DUR_BIT] ? FADE_CNT_W'(FADE_LONG_CYC - 1)
                                         : FADE_CNT_W'(FADE_SHORT_CYC - 1);
  assign fadeRun = blCtrl_q[BL_FADE_BIT];

  // counter idles at zero while fading is off
  always_ff @(posedge clk or negedge rstN_q)
  begin
    if (!rstN_q)
    begin
      fadeCnt_q <= '0;
      fadeStep <= 1'b0;
    end
    else if (!fadeRun)
    begin
      fadeCnt_q <= '0;
      fadeStep <= 1'b0;
    end
    else
    begin
      fadeStep <= (fadeCnt_q >= fadeLast);
      fadeCnt_q <= (fadeCnt_q >= fadeLast) ? '0 : fadeCnt_q + 1'b1;
    end
  end

  // ******************************************************************
  // registered driver outputs
  // ******************************************************************
  // registered so drivers never see decode glitches
  always_ff @(posedge clk or negedge rstN_q)
  begin
    if (!rstN_q)
    begin
      keyCfg <= '0;
      blCfg <= '0;
    end
    else
    begin
      keyCfg <= keyCfg_d;
      blCfg <= blCfg_d;
    end
  end

endmodule : llc_regs
`default_nettype wire

// >>> verification/llc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ********************************************************************
// serial host on the far side of the control port
// ********************************************************************
module llc_host_model #(
  parameter logic [6:0] DEV_ADDR = llc_pkg::DEV_ADDR_DEFAULT // arbitrary value
)
(
  // clock
  input wire logic clk,
  // device pin drive
  input wire logic sdaOut,
  input wire logic sdaOeN,
  // wire levels
  output var logic sclPin,
  output wire logic sdaLine
);
  import llc_pkg::*;
  localparam int HALF = 10; // clock phase, well above the pin filter
  logic sdaQ; // host side of the open-drain data line
  // pull-up wins unless someone pulls low
  assign sdaLine = sdaQ & (sdaOeN | sdaOut);
  initial
  begin
    sclPin = 1'b1;
    sdaQ = 1'b1;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step
  // data moves 5 clk after the fall, so the lagging filter never sees
  // a data change while its copy of the clock is still high
  task automatic bitIo(input logic b, output logic r);
    step(5);
    sdaQ <= b;
    step(HALF);
    sclPin <= 1'b1;
    step(HALF);
    r = sdaLine;
    sclPin <= 1'b0;
  endtask : bitIo
  task automatic start();
    step(5);
    sdaQ <= 1'b1;
    step(HALF);
    sclPin <= 1'b1;
    step(HALF);
    sdaQ <= 1'b0;
    step(HALF);
    sclPin <= 1'b0;
  endtask : start
  task automatic stop();
    step(5);
    sdaQ <= 1'b0;
    step(HALF);
    sclPin <= 1'b1;
    step(HALF);
    sdaQ <= 1'b1;
    step(HALF);
  endtask : stop
  // bytes go msb first, then the device's acknowledge
  task automatic byteOut(input logic [7:0] b, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) bitIo(b[i], r);
    bitIo(1'b1, nak);
  endtask : byteOut
  task automatic byteIn(input logic nakIt, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitIo(1'b1, d[i]);
    bitIo(nakIt, r);
  endtask : byteIn
  // write n (1 or 2) bytes from pointer ptr; ok when all were acknowledged
  task automatic wrN(input logic [7:0] ptr, input logic [7:0] d0, input logic [7:0] d1,
    input int n, output logic ok);
    logic a0, a1, a2, a3;
    a3 = 1'b0;
    start();
    byteOut({DEV_ADDR, 1'b0}, a0);
    byteOut(ptr, a1);
    byteOut(d0, a2);
    if (n > 1) byteOut(d1, a3);
    stop();
    ok = !(a0 | a1 | a2 | a3);
  endtask : wrN
  task automatic rdReg(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start();
    byteOut({DEV_ADDR, 1'b0}, a0);
    byteOut(ptr, a1);
    start();
    byteOut({DEV_ADDR, 1'b1}, a2);
    byteIn(1'b1, d);
    stop();
    ok = !(a0 | a1 | a2);
  endtask : rdReg
  // two bytes in one read: the first is acknowledged, the second refused
  task automatic rd2(input logic [7:0] ptr, output logic [15:0] d, output logic ok);
    logic a0, a1, a2;
    start();
    byteOut({DEV_ADDR, 1'b0}, a0);
    byteOut(ptr, a1);
    start();
    byteOut({DEV_ADDR, 1'b1}, a2);
    byteIn(1'b0, d[15:8]);
    byteIn(1'b1, d[7:0]);
    stop();
    ok = !(a0 | a1 | a2);
  endtask : rd2
endmodule : llc_host_model
`default_nettype wire

// >>> verification/llc_regs_props.sv
`timescale 1ns/10ps
`default_nettype none
// ********************************************************************
// checker for the lighting register bank ports
// ********************************************************************
module llc_regs_props #(
  parameter int FADE_SHORT_CYC = llc_pkg::FADE_SHORT_STEP_CYC,
  parameter int FADE_LONG_CYC = llc_pkg::FADE_LONG_STEP_CYC
)
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // serial pins
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOeN,
  // driver settings
  input wire llc_pkg::llc_key_t keyCfg,
  input wire llc_pkg::llc_bl_t blCfg,
  input wire logic fadeStep
);
  import llc_pkg::*;
  int gapQ; // cycles since the last fade step
  logic keepQ; // backlight settings unchanged since the last step
  llc_bl_t blPrevQ; // backlight settings one cycle ago
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // step spacing is only judged when nothing was rewritten in between,
  // since a rewrite may restart the design's counter
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      gapQ <= 0;
      keepQ <= 1'b0;
      blPrevQ <= '0;
    end
    else
    begin
      blPrevQ <= blCfg;
      gapQ <= fadeStep ? 1 : gapQ + 1;
      keepQ <= (fadeStep | keepQ) & (blCfg == blPrevQ);
    end
  end
  sda_open_drain_a: assert property (sdaOut == 1'b0)
    else $error("data pin value not low");
  fade_one_target_a: assert property (!(blCfg.fadePrimary && blCfg.fadeSecondary))
    else $error("fade aimed at both strings");
  fade_needs_enable_a: assert property (fadeStep |-> blCfg.fadePrimary || blCfg.fadeSecondary)
    else $error("fade step while fade is off");
  fade_pulse_one_a: assert property (fadeStep |=> !fadeStep)
    else $error("fade step longer than one cycle");
  fade_step_period_a: assert property (fadeStep && keepQ && blCfg == blPrevQ |->
    gapQ == (blCfg.fadeLong ? FADE_LONG_CYC : FADE_SHORT_CYC))
    else $error("fade step spacing wrong");
  ack_scl_low_a: assert property ($changed(sdaOeN) |-> !sclIn)
    else $error("data pin moved while clock high");
  ack_stands_a: assert property ($fell(sdaOeN) |=> (!sdaOeN) [*5])
    else $error("data pin pull too short");
  reset_style_a: assert property ($rose(nrst) |-> ##[1:5] keyCfg.switchMode)
    else $error("switch mode not set after reset");
  key_write_ack_a: assert property ($changed(keyCfg) && $past(nrst, 5) |-> !sdaOeN)
    else $error("keypad settings moved outside a write");
  bl_write_ack_a: assert property ($changed(blCfg) |-> !sdaOeN)
    else $error("backlight settings moved outside a write");
  // main scenarios
  cover property (fadeStep && blCfg.fadeLong);
  cover property ($fell(sdaOeN));
  cover property ($changed(keyCfg.active));
  cover property (blCfg.gang);
endmodule : llc_regs_props
bind llc_regs llc_regs_props #(.FADE_SHORT_CYC(FADE_SHORT_CYC), .FADE_LONG_CYC(FADE_LONG_CYC))
  props (.clk(clk), .nrst(nrst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOeN(sdaOeN), .keyCfg(keyCfg), .blCfg(blCfg), .fadeStep(fadeStep));
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
// ********************************************************************
// register bank testbench
// ********************************************************************
module testbench;
  import llc_pkg::*;
  localparam int SHORT = 10; // shortened fade step counts
  localparam int LONG = 20;
  logic clk, nrst, sclPin, sdaLine, sdaOut, sdaOeN, fadeStep;
  llc_key_t keyCfg;
  llc_bl_t blCfg;
  int err_total;
  int compares;
  logic [7:0] offs [5] = '{REG_KEY_CTRL, REG_KEY_BAL, REG_KEY_CAP, REG_BL_CTRL, REG_EXT_PWM};
  logic [7:0] masks [5] = '{MASK_KEY_CTRL, MASK_KEY_BAL, MASK_KEY_CAP, MASK_BL_CTRL, MASK_EXT_PWM};
  logic [7:0] rsts [5] = '{RST_KEY_CTRL, RST_KEY_BAL, RST_KEY_CAP, RST_BL_CTRL, RST_EXT_PWM};
  llc_regs #(.FADE_SHORT_CYC(SHORT), .FADE_LONG_CYC(LONG)) uut (.clk(clk), .nrst(nrst),
    .sclIn(sclPin), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .keyCfg(keyCfg),
    .blCfg(blCfg), .fadeStep(fadeStep));
  llc_host_model host (.clk(clk), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .sclPin(sclPin),
    .sdaLine(sdaLine));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic results();
    if (err_total == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  task automatic cmpByte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmpByte
  task automatic cmpField(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmpField
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host.wrN(a, d, 8'h00, 1, ok);
    cmpField(ok, 1'b1);
  endtask : wr
  task automatic chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host.rdReg(a, d, ok);
    cmpField(ok, 1'b1);
    cmpByte(d, exp);
  endtask : chk
  // cycles between two fade steps; a missing first step ends the run
  task automatic gap(output int n);
    int i;
    n = 0;
    // step off the edge so the first look never races the pulse
    #1;
    for (i = 0; i < 300 && fadeStep !== 1'b1; i++) @(posedge clk) #1;
    if (fadeStep !== 1'b1)
    begin
      err_total++;
      results();
    end
    else
    begin
      do begin @(posedge clk) #1; n++; end while (n < 300 && fadeStep !== 1'b1);
    end
  endtask : gap
  task automatic tReset();
    for (int i = 0; i < 5; i++) chk(offs[i], rsts[i]);
    cmpField(keyCfg.switchMode, 1'b1);
    cmpField(keyCfg.active, 3'h0);
    cmpField(blCfg, 8'h00);
  endtask : tReset
  task automatic tMasks();
    for (int i = 0; i < 5; i++)
    begin
      wr(offs[i], 8'hFF);
      chk(offs[i], masks[i]);
      wr(offs[i], 8'h00);
      chk(offs[i], 8'h00);
    end
  endtask : tMasks
  task automatic tKeyCtl();
    wr(REG_KEY_CTRL, 8'h8E); // keys on, master off
    cmpField(keyCfg.pwmOn, 1'b1);
    cmpField(keyCfg.active, 3'h0);
    cmpField(keyCfg.switchMode, 1'b0);
    wr(REG_KEY_CTRL, 8'h4A);
    cmpField(keyCfg.active, 3'h5);
    cmpField(keyCfg.pwmOn, 1'b0);
    wr(REG_KEY_CTRL, 8'h64);
    cmpField(keyCfg.active, 3'h2);
    cmpField(keyCfg.switchMode, 1'b1);
  endtask : tKeyCtl
  task automatic tBurst();
    logic ok;
    logic [15:0] w;
    host.wrN(REG_KEY_BAL, 8'h35, 8'h1B, 2, ok); // pointer steps to the cap register
    cmpField(ok, 1'b1);
    cmpField(keyCfg.balance, 3'h3);
    cmpField(keyCfg.level, 3'h2);
    cmpField(keyCfg.overlap, 1'b1);
    cmpField({keyCfg.oneCap, keyCfg.twoCap, keyCfg.threeCap}, 6'h1B);
    wr(REG_KEY_CAP, 8'hE4);
    cmpField({keyCfg.oneCap, keyCfg.twoCap, keyCfg.threeCap}, 6'h24);
    wr(REG_KEY_BAL, 8'h4A);
    cmpField({keyCfg.balance, keyCfg.level, keyCfg.overlap}, 7'h4A);
    host.rd2(REG_KEY_BAL, w, ok); // acknowledged first byte keeps the read going
    cmpField({ok, w}, {1'b1, 8'h4A, 8'h24});
  endtask : tBurst
  task automatic tBacklight();
    int n;
    wr(REG_BL_CTRL, 8'h0B);
    cmpField({blCfg.fadePrimary, blCfg.fadeSecondary}, 2'h2);
    cmpField({blCfg.gang, blCfg.primaryOn, blCfg.secondaryOn}, 3'h3);
    gap(n);
    cmpField(n, SHORT);
    wr(REG_BL_CTRL, 8'h3D);
    cmpField({blCfg.fadeLong, blCfg.fadePrimary, blCfg.fadeSecondary}, 3'h5);
    cmpField({blCfg.gang, blCfg.primaryOn, blCfg.secondaryOn}, 3'h5);
    gap(n);
    cmpField(n, LONG);
    wr(REG_BL_CTRL, 8'h06);
    n = 0;
    repeat (60) @(posedge clk) #1 n += fadeStep;
    cmpField(n, 0);
    cmpField({blCfg.gang, blCfg.primaryOn, blCfg.secondaryOn}, 3'h6);
    wr(REG_EXT_PWM, 8'h1A);
    cmpField({keyCfg.extPwm, blCfg.primaryExt, blCfg.secondaryExt}, 5'h1A);
  endtask : tBacklight
  task automatic tRefuse();
    logic a;
    host.start();
    host.byteOut({DEV_ADDR_DEFAULT ^ 7'h01, 1'b0}, a);
    cmpField(a, 1'b1);
    host.byteOut(REG_KEY_CTRL, a);
    host.byteOut(8'hFF, a);
    host.stop();
    wr(8'h10, 8'hFF); // unmapped place is acknowledged and dropped
    chk(REG_KEY_CTRL, 8'h64);
  endtask : tRefuse
  // a reset in mid-run must bring every register back to its reset value
  task automatic tMidReset();
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    tReset();
  endtask : tMidReset
  initial
  begin
    err_total = 0;
    compares = 0;
    nrst = 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    tReset();
    tMasks();
    tKeyCtl();
    tBurst();
    tBacklight();
    tRefuse();
    tMidReset();
    results();
  end
endmodule : testbench
`default_nettype wire
